// File: rtl/msg_image_pkg.sv
`default_nettype none
package msg_image_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ctl_offset = 12'h500;
  localparam logic [11:0] substitute_upper_address_offset = 12'h504;
  localparam logic [11:0] bar_offset = 12'h508;
  localparam logic [11:0] status_offset = 12'h50C;
  // ----------------------------------------------------------------
  // field positions in the control register
  // ----------------------------------------------------------------
  localparam int image_enable_pos = 31;
  localparam int translation_enable_pos = 30;
  localparam int bar_en_pos = 29;
  localparam int size_lsb = 24;
  localparam int rtt_lsb = 16;
  localparam int gbl_pos = 15;
  localparam int ci_pos = 14;
  localparam int wtt_lsb = 8;
  localparam int keep_pos = 7;
  localparam int end_lsb = 5;
  localparam int mra_pos = 4;
  localparam int amt_lsb = 0;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [4:0] rtt_reset = 5'h0A;
  localparam logic [4:0] wtt_reset = 5'h02;
  localparam logic [1:0] end_reset = 2'h2;
  localparam logic [2:0] amt_max = 3'h4;
  localparam logic [7:0] fixed_fetch_bytes = 8'h08;
  localparam logic [11:0] shell_limit = 12'hFFF;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic image_enable;
    logic translation_enable;
    logic bar_en;
    logic [3:0] size_code;
    logic [4:0] read_type_code;
    logic global_select;
    logic ci;
    logic [4:0] write_type_code;
    logic keep;
    logic [1:0] endian;
    logic read_alias_enable;
    logic [2:0] amt;
  } ctl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [4:0] tt;
    logic gbl_n;
    logic ci_n;
    logic [1:0] endian;
    logic [7:0] bytes;
    logic from_hold;
  } proc_req_t;
endpackage
`default_nettype wire

// File: rtl/pci_msg_target_image_ctl.sv
// Function
// - translation enabled substitutes upper address bits, otherwise address passes unchanged.
// - base register enable clear: base register reads zero, writes ignored.
// - base register enable set: base register is readable and writable.
// - image size is 64 Kbyte times two to the size code.
// - size code picks compared lines, 31..16 at code 0 down to 31 alone.
// - reads drive the programmable read type code, reset to plain read.
// - writes drive the programmable write type code, reset to write with flush.
// - global select 0 asserts the global signal, 1 negates it.
// - cache-inhibit select 0 asserts cache inhibit, 1 negates it.
// - with hold enabled, next-address read is served from held prefetch data.
// - read to a non-matching address discards held prefetch data.
// - byte-order field: 00 little, 01 processor little, 10 big (reset), 11 true.
// - read alias turns memory read into read multiple with selected amount.
// - without aliasing a memory read prefetches exactly 8 bytes.
// - amount 000 is 8 bytes, doubling per step, 100 is 128, rest reserved.
// - every claimed PCI transaction arriving with no forward pending, except a read answered from held prefetch data, is forwarded onto the processor bus.
// - shell region ignores translation, hold and byte order, fetches 8 bytes.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pci_msg_target_image_ctl
  import msg_image_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pci_valid,
  input wire logic pci_write,
  input wire logic pci_mem_read_multiple,
  input wire logic [31:0] pci_addr,
  input wire logic proc_done,
  output logic [31:0] proc_addr,
  output logic [4:0] proc_transfer_type_lines,
  output logic proc_global_signal_n,
  output logic proc_cache_inhibit_signal_n,
  output logic [1:0] proc_endian_mode,
  output logic [7:0] proc_fetch_bytes,
  output logic proc_req_valid,
  output logic proc_req_write,
  output logic hold_hit
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ctl_t ctl;
    logic [15:0] substitute_upper_address;
    logic [15:0] bar;
    logic aw_got;
    logic [11:0] aw;
    logic w_got;
    logic [31:0] w;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic hold_valid;
    logic [31:0] hold_next;
    logic busy;
    logic [31:0] paddr;
    logic [4:0] ptt;
    logic pgbl_n;
    logic pci_n;
    logic [1:0] pend;
    logic [7:0] pbytes;
    logic pvalid;
    logic pwrite;
    logic phit;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic [31:0] ctl_word;
  logic [15:0] size_mask;
  logic [31:0] xlat_addr;
  logic shell_hit;
  logic [7:0] fetch_bytes;
  logic [31:0] merged;

  always_comb
  begin
    ctl_word = '0;
    ctl_word[image_enable_pos] = cur_ff.ctl.image_enable;
    ctl_word[translation_enable_pos] = cur_ff.ctl.translation_enable;
    ctl_word[bar_en_pos] = cur_ff.ctl.bar_en;
    ctl_word[size_lsb +: 4] = cur_ff.ctl.size_code;
    ctl_word[rtt_lsb +: 5] = cur_ff.ctl.read_type_code;
    ctl_word[gbl_pos] = cur_ff.ctl.global_select;
    ctl_word[ci_pos] = cur_ff.ctl.ci;
    ctl_word[wtt_lsb +: 5] = cur_ff.ctl.write_type_code;
    ctl_word[keep_pos] = cur_ff.ctl.keep;
    ctl_word[end_lsb +: 2] = cur_ff.ctl.endian;
    ctl_word[mra_pos] = cur_ff.ctl.read_alias_enable;
    ctl_word[amt_lsb +: 3] = cur_ff.ctl.amt;
  end

  // ----------------------------------------------------------------
  // address compare and translation
  // ----------------------------------------------------------------
  // mask of upper lines in use: code 0 keeps 31..16, code 15 keeps 31 only
  assign size_mask = 16'hFFFF << cur_ff.ctl.size_code;
  assign shell_hit = (pci_addr[15:12] == 4'h0) && ((pci_addr[31:16] & size_mask) == (cur_ff.bar & size_mask))
                     && ((pci_addr[15:0] & {4'h0, shell_limit}) == pci_addr[15:0]);
  assign xlat_addr = {(cur_ff.substitute_upper_address & size_mask) | (pci_addr[31:16] & ~size_mask), pci_addr[15:0]};

  always_comb
  begin
    if (shell_hit || !pci_mem_read_multiple && !cur_ff.ctl.read_alias_enable)
      fetch_bytes = fixed_fetch_bytes;
    else if (cur_ff.ctl.amt > amt_max)
      fetch_bytes = fixed_fetch_bytes; // reserved codes fall back to smallest fetch
    else
      fetch_bytes = fixed_fetch_bytes << cur_ff.ctl.amt;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    merged = '0;
    nxt_cur.pvalid = 1'b0;
    nxt_cur.phit = 1'b0;
    // bus write channel: address and data taken in either order
    if (s_axi_awvalid && cur_ff.awrdy)
    begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur_ff.wrdy)
    begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.w = s_axi_wdata;
      nxt_cur.ws = s_axi_wstrb;
    end
    if (cur_ff.aw_got && cur_ff.w_got)
    begin
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = resp_okay;
      for (int i = 0; i < 4; i++)
        merged[i*8 +: 8] = cur_ff.ws[i] ? cur_ff.w[i*8 +: 8] : ctl_word[i*8 +: 8];
      if (cur_ff.aw == ctl_offset)
      begin
        nxt_cur.ctl.image_enable = merged[image_enable_pos];
        nxt_cur.ctl.translation_enable = merged[translation_enable_pos];
        nxt_cur.ctl.bar_en = merged[bar_en_pos];
        nxt_cur.ctl.size_code = merged[size_lsb +: 4];
        nxt_cur.ctl.read_type_code = merged[rtt_lsb +: 5];
        nxt_cur.ctl.global_select = merged[gbl_pos];
        nxt_cur.ctl.ci = merged[ci_pos];
        nxt_cur.ctl.write_type_code = merged[wtt_lsb +: 5];
        nxt_cur.ctl.keep = merged[keep_pos];
        nxt_cur.ctl.endian = merged[end_lsb +: 2];
        nxt_cur.ctl.read_alias_enable = merged[mra_pos];
        nxt_cur.ctl.amt = merged[amt_lsb +: 3];
      end
      else if (cur_ff.aw == substitute_upper_address_offset)
      begin
        if (cur_ff.ws[2])
          nxt_cur.substitute_upper_address[7:0] = cur_ff.w[23:16];
        if (cur_ff.ws[3])
          nxt_cur.substitute_upper_address[15:8] = cur_ff.w[31:24];
      end
      else if (cur_ff.aw == bar_offset)
      begin
        if (cur_ff.ctl.bar_en)
        begin
          if (cur_ff.ws[2])
            nxt_cur.bar[7:0] = cur_ff.w[23:16];
          if (cur_ff.ws[3])
            nxt_cur.bar[15:8] = cur_ff.w[31:24];
        end
      end
      else if (cur_ff.aw != status_offset)
        nxt_cur.bresp = resp_slverr;
    end
    if (cur_ff.bvalid && s_axi_bready)
      nxt_cur.bvalid = 1'b0;
    // bus read channel
    if (s_axi_arvalid && cur_ff.arrdy)
    begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = resp_okay;
      nxt_cur.rdata = '0;
      if (s_axi_araddr == ctl_offset)
        nxt_cur.rdata = ctl_word;
      else if (s_axi_araddr == substitute_upper_address_offset)
        nxt_cur.rdata = {cur_ff.substitute_upper_address, 16'h0000};
      else if (s_axi_araddr == bar_offset)
        nxt_cur.rdata = cur_ff.ctl.bar_en ? {cur_ff.bar, 16'h0000} : 32'h0000_0000;
      else if (s_axi_araddr == status_offset)
        nxt_cur.rdata = {30'h0, cur_ff.busy, cur_ff.hold_valid};
      else
        nxt_cur.rresp = resp_slverr;
    end
    if (cur_ff.rvalid && s_axi_rready)
      nxt_cur.rvalid = 1'b0;
    // forwarding of claimed transactions, one at a time
    if (proc_done)
      nxt_cur.busy = 1'b0;
    if (pci_valid && !cur_ff.busy && cur_ff.ctl.image_enable
        && ((pci_addr[31:16] & size_mask) == (cur_ff.bar & size_mask)))
    begin
      if (!pci_write && cur_ff.hold_valid && cur_ff.ctl.keep && !shell_hit && pci_addr == cur_ff.hold_next)
      begin
        // held data answers; no new fetch leaves the block
        nxt_cur.phit = 1'b1;
        nxt_cur.hold_next = pci_addr + 32'h0000_0004;
      end
      else
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.pvalid = 1'b1;
        nxt_cur.pwrite = pci_write;
        nxt_cur.paddr = (cur_ff.ctl.translation_enable && !shell_hit) ? xlat_addr : pci_addr;
        nxt_cur.ptt = pci_write ? cur_ff.ctl.write_type_code : cur_ff.ctl.read_type_code;
        nxt_cur.pgbl_n = cur_ff.ctl.global_select;
        nxt_cur.pci_n = cur_ff.ctl.ci;
        nxt_cur.pend = shell_hit ? end_reset : cur_ff.ctl.endian;
        nxt_cur.pbytes = pci_write ? 8'h00 : fetch_bytes;
        // a miss drops held data; a keeping read refills it past the first word
        nxt_cur.hold_valid = !pci_write && cur_ff.ctl.keep && !shell_hit && fetch_bytes > 8'h04;
        nxt_cur.hold_next = pci_addr + 32'h0000_0004;
      end
    end
    if (!cur_ff.ctl.keep)
      nxt_cur.hold_valid = 1'b0;
    // readies registered: no bus output runs through gates, low in reset
    nxt_cur.awrdy = !nxt_cur.aw_got && !nxt_cur.bvalid;
    nxt_cur.wrdy = !nxt_cur.w_got && !nxt_cur.bvalid;
    nxt_cur.arrdy = !nxt_cur.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_ff <= '0;
      cur_ff.ctl.read_type_code <= rtt_reset;
      cur_ff.ctl.write_type_code <= wtt_reset;
      cur_ff.ctl.endian <= end_reset;
      cur_ff.pend <= end_reset;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = cur_ff.awrdy;
  assign s_axi_wready = cur_ff.wrdy;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_arready = cur_ff.arrdy;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;
  assign proc_addr = cur_ff.paddr;
  assign proc_transfer_type_lines = cur_ff.ptt;
  assign proc_global_signal_n = cur_ff.pgbl_n;
  assign proc_cache_inhibit_signal_n = cur_ff.pci_n;
  assign proc_endian_mode = cur_ff.pend;
  assign proc_fetch_bytes = cur_ff.pbytes;
  assign proc_req_valid = cur_ff.pvalid;
  assign proc_req_write = cur_ff.pwrite;
  assign hold_hit = cur_ff.phit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_read_type;
    @(posedge aclk) disable iff (!aresetn)
      (proc_req_valid && !proc_req_write) |-> proc_transfer_type_lines == $past(cur_ff.ctl.read_type_code);
  endproperty
  a_read_type: assert property (p_read_type) else $error("read type wrong");

  property p_write_type;
    @(posedge aclk) disable iff (!aresetn)
      (proc_req_valid && proc_req_write) |-> proc_transfer_type_lines == $past(cur_ff.ctl.write_type_code);
  endproperty
  a_write_type: assert property (p_write_type) else $error("write type wrong");

  property p_global;
    @(posedge aclk) disable iff (!aresetn)
      proc_req_valid |-> proc_global_signal_n == $past(cur_ff.ctl.global_select);
  endproperty
  a_global: assert property (p_global) else $error("global level wrong");

  property p_cache;
    @(posedge aclk) disable iff (!aresetn)
      proc_req_valid |-> proc_cache_inhibit_signal_n == $past(cur_ff.ctl.ci);
  endproperty
  a_cache: assert property (p_cache) else $error("cache inhibit level wrong");

  property p_bar_hidden;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == bar_offset && !cur_ff.ctl.bar_en) |=> s_axi_rdata == 32'h0;
  endproperty
  a_bar_hidden: assert property (p_bar_hidden) else $error("hidden base reg not zero");

  property p_fetch_size;
    @(posedge aclk) disable iff (!aresetn)
      (proc_req_valid && !proc_req_write) |-> proc_fetch_bytes inside {8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  endproperty
  a_fetch_size: assert property (p_fetch_size) else $error("fetch size illegal");

  property p_no_xlat;
    @(posedge aclk) disable iff (!aresetn)
      (pci_valid && !cur_ff.busy && cur_ff.ctl.image_enable && !cur_ff.ctl.translation_enable && !cur_ff.hold_valid)
      |=> !proc_req_valid || proc_addr == $past(pci_addr);
  endproperty
  a_no_xlat: assert property (p_no_xlat) else $error("untranslated address changed");

  property p_hit_no_fetch;
    @(posedge aclk) disable iff (!aresetn)
      hold_hit |-> !proc_req_valid;
  endproperty
  a_hit_no_fetch: assert property (p_hit_no_fetch) else $error("held hit fetched");
endmodule
`default_nettype wire

// File: verif/proc_target_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// processor bus target: ends each forward lag+1 cycles after the edge that takes its request
// ----------------------------------------------------------------
module proc_target_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic proc_req_valid,
  input wire logic [3:0] lag,
  output logic proc_done
);
  logic [3:0] cnt_ff;
  logic run_ff;
  always_ff @(posedge aclk)
  begin
    proc_done <= 1'b0;
    if (!aresetn)
    begin
      cnt_ff <= 4'h0;
      run_ff <= 1'b0;
    end
    else if (proc_req_valid)
    begin
      cnt_ff <= lag;
      run_ff <= 1'b1;
    end
    else if (run_ff && cnt_ff == 4'h0)
    begin
      proc_done <= 1'b1;
      run_ff <= 1'b0;
    end
    else if (run_ff)
      cnt_ff <= cnt_ff - 4'h1;
  end
endmodule
`default_nettype wire

// File: verif/pci_msg_target_image_ctl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pci_msg_target_image_ctl_bench import msg_image_pkg::*;;
  logic aclk, aresetn, awv, wv, bre, arv, rre, pv, pw, pm, done, awr, wr, bv, arr, rv, rqv, rqw, hit, gn, cn;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, pa, qa, rdat;
  logic [3:0] lag;
  logic [1:0] br, rr, em, rresp, wresp;
  logic [4:0] tt;
  logic [7:0] fb;
  logic req_seen, hit_seen;
  int mismatches, num_checks;
  pci_msg_target_image_ctl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .pci_valid(pv), .pci_write(pw), .pci_mem_read_multiple(pm), .pci_addr(pa), .proc_done(done),
    .proc_addr(qa), .proc_transfer_type_lines(tt), .proc_global_signal_n(gn),
    .proc_cache_inhibit_signal_n(cn), .proc_endian_mode(em), .proc_fetch_bytes(fb),
    .proc_req_valid(rqv), .proc_req_write(rqw), .hold_hit(hit));
  proc_target_model partner (.aclk(aclk), .aresetn(aresetn), .proc_req_valid(rqv), .lag(lag), .proc_done(done));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // handshakes looked at on the falling edge: readies come from flops, so no race
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      wresp = br;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    bre <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic tr, tv;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    forever
    begin
      @(negedge aclk);
      tr = arv && arr;
      tv = rv;
      rdat = rd;
      rresp = rr;
      @(posedge aclk);
      if (tr) arv <= 1'b0;
      if (tv) break;
    end
    rre <= 1'b0;
  endtask
  // image on, base visible, read type 0C, write type 06
  function automatic logic [31:0] cw(input logic [3:0] sz, input logic ta, input logic [1:0] gc,
    input logic keep, input logic [1:0] en, input logic read_alias_enable, input logic [2:0] amt);
    cw = 32'hA00C_0600 | (32'(ta) << translation_enable_pos) | (32'(sz) << size_lsb) | (32'(gc) << ci_pos)
      | (32'(keep) << keep_pos) | (32'(en) << end_lsb) | (32'(read_alias_enable) << mra_pos) | 32'(amt);
  endfunction
  task automatic fwd(input logic w, input logic [31:0] a);
    pw <= w;
    pa <= a;
    pv <= 1'b1;
    @(posedge aclk);
    pv <= 1'b0;
    // request and hit pulses stand only until the next edge
    #1;
    req_seen = rqv;
    hit_seen = hit;
    repeat (10) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    axi_rd(ctl_offset);
    chk(rdat, 32'h000A_0240);
    chk(32'(em), 32'h2);
  endtask
  task automatic t_bar();
    axi_wr(bar_offset, 32'h1234_0000);
    axi_rd(bar_offset);
    chk(rdat, 32'h0);
    axi_wr(ctl_offset, 32'h2000_0000);
    axi_rd(bar_offset);
    chk(rdat, 32'h0);
    axi_wr(bar_offset, 32'h1234_0000);
    chk(32'(wresp), 32'(resp_okay));
    axi_rd(bar_offset);
    chk(rdat, 32'h1234_0000);
    axi_rd(12'h7F0);
    chk(32'(rresp), 32'(resp_slverr));
    axi_wr(12'h7F0, 32'h0);
    chk(32'(wresp), 32'(resp_slverr));
  endtask
  task automatic t_claim();
    axi_wr(ctl_offset, cw(4'h0, 1'b0, 2'b10, 1'b0, 2'h2, 1'b0, 3'h4));
    fwd(1'b0, 32'h1235_0010);
    chk(32'(req_seen), 32'h0);
    axi_wr(ctl_offset, cw(4'h1, 1'b0, 2'b10, 1'b0, 2'h2, 1'b0, 3'h4));
    fwd(1'b0, 32'h1235_0010);
    chk(32'(req_seen), 32'h1);
    chk(qa, 32'h1235_0010);
    chk({27'h0, tt}, 32'h0C);
    chk({30'h0, gn, cn}, 32'h2);
    chk(32'(fb), 32'h8);
    fwd(1'b0, 32'h1236_0010);
    chk(32'(req_seen), 32'h0);
    lag <= 4'h0;
    axi_wr(ctl_offset, cw(4'h1, 1'b0, 2'b01, 1'b0, 2'h2, 1'b0, 3'h0));
    fwd(1'b0, 32'h1234_8000);
    chk({30'h0, gn, cn}, 32'h1);
  endtask
  task automatic t_translate();
    axi_wr(substitute_upper_address_offset, 32'hABCD_0000);
    axi_wr(ctl_offset, cw(4'h1, 1'b1, 2'b10, 1'b0, 2'h0, 1'b1, 3'h2));
    fwd(1'b1, 32'h1234_5678);
    chk(qa, 32'hABCC_5678);
    chk({26'h0, rqw, tt}, 32'h26);
    fwd(1'b0, 32'h1234_0100);
    chk(qa, 32'h1234_0100);
    chk({22'h0, em, fb}, 32'h208);
  endtask
  task automatic t_amount();
    logic [2:0] k;
    for (int i = 0; i < 6; i++)
    begin
      k = 3'(i);
      axi_wr(ctl_offset, cw(4'h1, 1'b0, 2'b10, 1'b0, k[1:0], 1'b1, k));
      fwd(1'b0, 32'h1234_1000);
      chk(32'(fb), (i < 5) ? (32'h8 << i) : 32'h8);
      chk(32'(em), 32'(k[1:0]));
    end
    axi_wr(ctl_offset, cw(4'h1, 1'b0, 2'b10, 1'b0, 2'h2, 1'b0, 3'h3));
    fwd(1'b0, 32'h1234_1000);
    chk(32'(fb), 32'h8);
    pm <= 1'b1;
    fwd(1'b0, 32'h1234_1000);
    chk(32'(fb), 32'h40);
    pm <= 1'b0;
  endtask
  task automatic t_hold();
    lag <= 4'h6;
    axi_wr(ctl_offset, cw(4'h1, 1'b0, 2'b10, 1'b1, 2'h2, 1'b1, 3'h1));
    fwd(1'b0, 32'h1234_2000);
    chk({30'h0, req_seen, hit_seen}, 32'h2);
    fwd(1'b0, 32'h1234_2004);
    chk({30'h0, req_seen, hit_seen}, 32'h1);
    fwd(1'b0, 32'h1234_3000);
    chk({30'h0, req_seen, hit_seen}, 32'h2);
    fwd(1'b0, 32'h1234_2008);
    chk({30'h0, req_seen, hit_seen}, 32'h2);
  endtask
  task automatic t_rereset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    axi_rd(bar_offset);
    chk(rdat, 32'h0);
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    {aresetn, awv, wv, bre, arv, rre, pv, pw, pm} = 9'h0;
    {awa, ara, wd, pa} = 88'h0;
    lag = 4'h2;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bar();
    t_claim();
    t_translate();
    t_amount();
    t_hold();
    t_rereset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
